//--- core/wdg_device.sv
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// R01: expiry reset pulse exactly one clock
// R02: dog cause bit set, cleared by zero
// R03: brownout cause bit set, cleared by zero
// R04: pin cause bit set, cleared by zero
// R05: poweron bit cleared only by software zero
// R06: counter advances on 128 kHz oscillator ticks
// R07: restart returns counter to zero
// R08: interrupt mode raises request, wakes sleep
// R09: reset mode expiry fires reset pulse
// R10: combined: interrupt first, then reset mode
// R11: fuse forces reset enable on, irq off
// R12: clear enable/period only inside unlock window
// R13: unlock needs change and enable together
// R14: final write within four cycles, unlock zero
// R15: periods from about 16ms to 8s
// R16: stays enabled after watchdog reset
// R17: init software clears dog flag, then enable
// R18: dog flag forces reset enable high
// R19: unlock bit self-clears after four cycles
// R20: period 2048 ticks doubling, codes above nine reserved
// R21: irq flag cleared by vector or write one
// R22: oscillator events synchronised into clock domain
module wdg_device
    import wdg_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register bus
    wdg_if.device bus,
    // reset sources, reset controller, fuse
    input wire logic poweron_rst,
    input wire logic brownout_rst,
    input wire logic pin_rst,
    input wire logic guard_always_on_fuse,
    output logic dog_reset_pulse,
    output logic guard_irq
);
    import wdg_pkg::*;

    logic [7:0] cause_ff;
    logic irq_flag_ff, irq_en_ff, rst_en_ff;
    logic [3:0] per_ff;
    logic [2:0] unlock_ff;
    logic [9:0] osc_div_ff;
    logic osc_tick_ff, osc_tog_ff, tog_s1_ff, tog_s2_ff, tog_s3_ff;
    logic [20:0] cnt_ff;
    logic expire_tog_ff, exp_s1_ff, exp_s2_ff, exp_s3_ff;
    logic pulse_ff, ack_ff;
    logic [7:0] rdat_ff;

    // bus decode
    wire access = bus.cyc && bus.stb && !ack_ff;
    wire wr = access && bus.we;
    wire wr_ctrl = wr && (bus.adr == WDG_ADR_CTRL);
    wire wr_cause = wr && (bus.adr == WDG_ADR_CAUSE);
    wire wr_cmd = wr && (bus.adr == WDG_ADR_CMD);
    wire restart = wr_cmd && bus.dat_w[WDG_BIT_RESTART];
    wire vector = wr_cmd && bus.dat_w[WDG_BIT_VECTOR];
    wire unlocked = unlock_ff != 3'h0;
    wire [3:0] wr_per = {bus.dat_w[WDG_BIT_PER3], bus.dat_w[2:0]};
    wire open_req = wr_ctrl && bus.dat_w[WDG_BIT_UNLOCK] && bus.dat_w[WDG_BIT_RST_EN];
    // R11: fuse override of mode bits
    wire rst_en_eff = rst_en_ff || guard_always_on_fuse || cause_ff[WDG_BIT_DOG];
    wire irq_en_eff = irq_en_ff && !guard_always_on_fuse;
    wire [1:0] mode = {rst_en_eff, irq_en_eff};
    // R15: R20: terminal count by period code
    wire [20:0] limit = 21'(WDG_BASE_TICKS) << per_ff;
    wire expire_evt = exp_s2_ff ^ exp_s3_ff;
    wire tick_evt = tog_s2_ff ^ tog_s3_ff;
    wire [7:0] ctrl_rd_v = {irq_flag_ff, irq_en_eff, per_ff[3], unlocked, rst_en_eff, per_ff[2:0]};

    // R06: free running 128 kHz oscillator model with its own toggle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            osc_div_ff <= 10'h000;
            osc_tog_ff <= 1'b0;
        end else if (osc_div_ff == WDG_OSC_DIV_CNT) begin
            osc_div_ff <= 10'h000;
            osc_tog_ff <= !osc_tog_ff;
        end else begin
            osc_div_ff <= osc_div_ff + 10'h001;
        end
    end

    // R22: tick and expiry crossing, two flops then edge detect
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            {tog_s1_ff, tog_s2_ff, tog_s3_ff} <= 3'h0;
            {exp_s1_ff, exp_s2_ff, exp_s3_ff} <= 3'h0;
        end else begin
            {tog_s3_ff, tog_s2_ff, tog_s1_ff} <= {tog_s2_ff, tog_s1_ff, osc_tog_ff};
            {exp_s3_ff, exp_s2_ff, exp_s1_ff} <= {exp_s2_ff, exp_s1_ff, expire_tog_ff};
        end
    end

    // R07: counter, restarted by command or expiry
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cnt_ff <= 21'h000000;
            expire_tog_ff <= 1'b0;
            osc_tick_ff <= 1'b0;
        end else begin
            osc_tick_ff <= tick_evt;
            if (restart || mode == WDG_STOPPED) begin
                cnt_ff <= 21'h000000;
            end else if (osc_tick_ff) begin
                if (cnt_ff + 21'h000001 >= limit) begin
                    cnt_ff <= 21'h000000;
                    expire_tog_ff <= !expire_tog_ff;
                end else begin
                    cnt_ff <= cnt_ff + 21'h000001;
                end
            end
        end
    end

    // R01: one-cycle reset pulse on reset-mode expiry
    wire fire_rst = expire_evt && (mode == WDG_RST || (mode == WDG_IRQ_RST && irq_flag_ff));
    wire fire_irq = expire_evt && (mode == WDG_IRQ || (mode == WDG_IRQ_RST && !irq_flag_ff));
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pulse_ff <= 1'b0;
        end else begin
            // R09: reset behaviour
            pulse_ff <= fire_rst;
        end
    end

    // R02: cause flags, set wins over clear
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cause_ff <= WDG_CAUSE_RST;
        end else if (poweron_rst) begin
            // R05: power-on clears others, sets its own
            cause_ff <= WDG_CAUSE_RST;
        end else begin
            // R03: R04: write zero clears, events set
            if (wr_cause) begin
                cause_ff[3:0] <= cause_ff[3:0] & bus.dat_w[3:0];
            end
            if (pulse_ff) begin
                cause_ff[WDG_BIT_DOG] <= 1'b1;
            end
            if (brownout_rst) begin
                cause_ff[WDG_BIT_BROWN] <= 1'b1;
            end
            if (pin_rst) begin
                cause_ff[WDG_BIT_PIN] <= 1'b1;
            end
        end
    end

    // control register with timed unlock
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            {irq_flag_ff, irq_en_ff} <= 2'b00;
            rst_en_ff <= WDG_CTRL_RST[WDG_BIT_RST_EN];
            per_ff <= 4'h0;
            unlock_ff <= 3'h0;
        end else begin
            // R19: unlock window self-closes
            if (open_req) begin
                unlock_ff <= WDG_UNLOCK_CNT;
            end else if (unlocked) begin
                unlock_ff <= unlock_ff - 3'h1;
            end
            if (wr_ctrl) begin
                irq_en_ff <= bus.dat_w[WDG_BIT_IRQ_EN];
                // R12: R14: clear or period change only when unlocked
                if (bus.dat_w[WDG_BIT_RST_EN]) begin
                    rst_en_ff <= 1'b1;
                end else if (unlocked && !bus.dat_w[WDG_BIT_UNLOCK]) begin
                    rst_en_ff <= 1'b0;
                end
                if (unlocked && !bus.dat_w[WDG_BIT_UNLOCK] && wr_per <= WDG_PER_MAX) begin
                    per_ff <= wr_per;
                end
            end
            // R16: R18: watchdog reset keeps the guard enabled
            if (pulse_ff) begin
                rst_en_ff <= 1'b1;
            end
            // R21: vector clears flag; combined mode also drops enable
            if (vector && irq_flag_ff && mode == WDG_IRQ_RST) begin
                irq_en_ff <= 1'b0;
            end
            // R08: R10: interrupt on expiry, set beats clear
            if (fire_irq) begin
                irq_flag_ff <= 1'b1;
            end else if (vector || (wr_ctrl && bus.dat_w[WDG_BIT_IRQ_FLAG])) begin
                irq_flag_ff <= 1'b0;
            end
        end
    end

    // bus answer, one cycle after strobe
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ack_ff <= 1'b0;
            rdat_ff <= 8'h00;
        end else begin
            ack_ff <= access;
            rdat_ff <= (bus.adr == WDG_ADR_CTRL) ? ctrl_rd_v :
                       (bus.adr == WDG_ADR_CAUSE) ? cause_ff : 8'h00;
        end
    end

    assign bus.ack = ack_ff;
    assign bus.dat_r = rdat_ff;
    assign dog_reset_pulse = pulse_ff;
    assign guard_irq = irq_flag_ff && irq_en_eff;
endmodule

//--- inc/wdg_pkg.sv
package wdg_pkg;
    // register indices on the wishbone side (word addresses)
    localparam logic [3:0] WDG_ADR_CTRL = 4'h0;
    localparam logic [3:0] WDG_ADR_CAUSE = 4'h4;
    localparam logic [3:0] WDG_ADR_CMD = 4'h8;
    // control/status field positions
    localparam int WDG_BIT_IRQ_FLAG = 7;
    localparam int WDG_BIT_IRQ_EN = 6;
    localparam int WDG_BIT_PER3 = 5;
    localparam int WDG_BIT_UNLOCK = 4;
    localparam int WDG_BIT_RST_EN = 3;
    // reset cause field positions
    localparam int WDG_BIT_DOG = 3;
    localparam int WDG_BIT_BROWN = 2;
    localparam int WDG_BIT_PIN = 1;
    localparam int WDG_BIT_POR = 0;
    // command register bits
    localparam int WDG_BIT_RESTART = 0;
    localparam int WDG_BIT_VECTOR = 1;
    // timing
    localparam int WDG_UNLOCK_CYCLES = 4;
    localparam logic [2:0] WDG_UNLOCK_CNT = 3'(WDG_UNLOCK_CYCLES);
    localparam int WDG_CLK_HZ = 100_000_000;
    localparam int WDG_OSC_HZ = 128_000;
    localparam int WDG_OSC_DIV = WDG_CLK_HZ / WDG_OSC_HZ;
    localparam logic [9:0] WDG_OSC_DIV_CNT = 10'(WDG_OSC_DIV - 1);
    localparam int WDG_BASE_TICKS = 2048;
    localparam logic [3:0] WDG_PER_MAX = 4'h9;
    localparam logic [7:0] WDG_CTRL_RST = 8'h00;
    localparam logic [7:0] WDG_CAUSE_RST = 8'h01;
    // watchdog behaviour
    typedef enum logic [1:0] {
        WDG_STOPPED = 2'b00,
        WDG_IRQ = 2'b01,
        WDG_IRQ_RST = 2'b11,
        WDG_RST = 2'b10
    } wdg_mode_e;
endpackage

//--- inc/wdg_if.sv
`timescale 1ns/1ns
interface wdg_if;
    // wishbone classic
    logic [3:0] adr;
    logic [7:0] dat_w;
    logic [7:0] dat_r;
    logic we;
    logic cyc;
    logic stb;
    logic ack;
    modport device (
        input adr, dat_w, we, cyc, stb,
        output dat_r, ack
    );
    modport host (
        output adr, dat_w, we, cyc, stb,
        input dat_r, ack
    );
endinterface

//--- core/wdg_host.sv
`timescale 1ns/1ns
module wdg_host
    import wdg_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register bus
    wdg_if.host bus,
    // user request side
    input wire logic req,
    input wire logic req_we,
    input wire logic [3:0] req_adr,
    input wire logic [7:0] req_dat,
    output logic busy,
    output logic done,
    output logic [7:0] rd_dat
);
    import wdg_pkg::*;

    logic [3:0] adr_ff;
    logic [7:0] dat_ff, rd_ff;
    logic we_ff, act_ff, done_ff;

    // R13: R14: R17: host issues writes as ordered by its user
    wire take = req && !act_ff;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            act_ff <= 1'b0;
            done_ff <= 1'b0;
            adr_ff <= 4'h0;
            dat_ff <= 8'h00;
            we_ff <= 1'b0;
            rd_ff <= 8'h00;
        end else begin
            done_ff <= 1'b0;
            if (take) begin
                act_ff <= 1'b1;
                adr_ff <= req_adr;
                dat_ff <= req_dat;
                we_ff <= req_we;
            end else if (act_ff && bus.ack) begin
                act_ff <= 1'b0;
                done_ff <= 1'b1;
                rd_ff <= bus.dat_r;
            end
        end
    end

    assign bus.cyc = act_ff;
    assign bus.stb = act_ff;
    assign bus.adr = adr_ff;
    assign bus.dat_w = dat_ff;
    assign bus.we = we_ff;
    assign busy = act_ff;
    assign done = done_ff;
    assign rd_dat = rd_ff;
endmodule

//--- test/wdg_bus_asserts.sv
`timescale 1ns/1ns
module wdg_bus_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // wishbone signals
    input wire logic [3:0] adr,
    input wire logic [7:0] dat_w,
    input wire logic [7:0] dat_r,
    input wire logic we,
    input wire logic cyc,
    input wire logic stb,
    input wire logic ack
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // steps of one classic transfer
    sequence s_take;
        cyc && stb && !ack;
    endsequence
    sequence s_answer;
        ack ##1 (!cyc && !stb && !ack);
    endsequence
    // properties on the bus between the two ends
    property p_ack_next;
        s_take |=> ack;
    endproperty
    property p_ack_one;
        ack |=> !ack;
    endproperty
    property p_ack_cause;
        ack |-> $past(cyc) && $past(stb);
    endproperty
    property p_hold;
        s_take |=> $stable(adr) && $stable(we) && $stable(dat_w);
    endproperty
    property p_release;
        ack |=> !cyc && !stb;
    endproperty
    property p_pair;
        cyc == stb;
    endproperty
    property p_idle;
        !cyc |=> !ack;
    endproperty
    property p_txn;
        s_take |=> s_answer;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_hold: assert property (p_hold) else $error("request changed before ack");
    a_release: assert property (p_release) else $error("request kept after ack");
    a_pair: assert property (p_pair) else $error("cyc and stb differ");
    a_idle: assert property (p_idle) else $error("ack while idle");
    a_txn: assert property (p_txn) else $error("transfer steps out of order");
    c_write: cover property (s_take ##0 we);
endmodule

//--- test/tb.sv
`timescale 1ns/1ns
module tb;
    import wdg_pkg::*;
    logic mclk = 1'h0;
    logic resetn = 1'h0;
    logic req = 1'h0;
    logic req_we = 1'h0;
    logic [3:0] req_adr = 4'h0;
    logic [7:0] req_dat = 8'h00;
    logic [2:0] src = 3'h0;
    logic fuse = 1'h0;
    logic busy, done;
    logic dog_pulse, irq_out;
    logic [1:0] seen = 2'h0;
    logic [7:0] rd_dat;
    int fails = 0;
    int cmp_count = 0;
    wdg_if bus ();
    wdg_device i_wdg_device (.mclk(mclk), .resetn(resetn), .bus(bus.device),
        .poweron_rst(src[2]), .brownout_rst(src[1]), .pin_rst(src[0]),
        .guard_always_on_fuse(fuse), .dog_reset_pulse(dog_pulse), .guard_irq(irq_out));
    wdg_host i_wdg_host (.mclk(mclk), .resetn(resetn), .bus(bus.host), .req(req),
        .req_we(req_we), .req_adr(req_adr), .req_dat(req_dat), .busy(busy),
        .done(done), .rd_dat(rd_dat));
    wdg_bus_asserts i_wdg_bus_asserts (.mclk(mclk), .resetn(resetn), .adr(bus.adr),
        .dat_w(bus.dat_w), .dat_r(bus.dat_r), .we(bus.we), .cyc(bus.cyc),
        .stb(bus.stb), .ack(bus.ack));
    // clock
    always #5 mclk = ~mclk;
    // outputs stay quiet: no expiry fits in this run
    always @(posedge mclk) begin
        if (resetn) begin
            seen <= seen | {dog_pulse, irq_out};
        end
    end
    // expected control value from period and reset enable
    function automatic logic [7:0] ctrl_val(input logic [3:0] p, input logic en);
        return {2'h0, p[3], 1'h0, en, p[2:0]};
    endfunction
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one register access through the host, entered at a rising edge
    task automatic op(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] r);
        int n;
        n = 0;
        req <= 1'h1;
        req_we <= w;
        req_adr <= a;
        req_dat <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (busy !== 1'h1 && n < 50);
        req <= 1'h0;
        do begin
            @(posedge mclk);
            n++;
        end while (done !== 1'h1 && n < 100);
        if (n >= 100) begin
            fails++;
            $display("wrong value at %0t: no done", $time);
        end
        r = rd_dat;
    endtask
    // one-cycle pulse on the reset sources
    task automatic raise(input logic [2:0] s);
        src <= s;
        @(posedge mclk);
        src <= 3'h0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #500000;
        fails++;
        conclude();
    end
    // main sequence
    initial begin
        logic [7:0] r;
        logic [3:0] cur;
        logic [3:0] per;
        void'($urandom(32'h15F0737D));
        repeat (8) @(posedge mclk);
        resetn <= 1'h1;
        @(posedge mclk);
        op(1'h0, WDG_ADR_CAUSE, 8'h00, r);
        check(r, WDG_CAUSE_RST);
        op(1'h0, WDG_ADR_CTRL, 8'h00, r);
        check(r, WDG_CTRL_RST);
        op(1'h0, 4'hC, 8'h00, r);
        check(r, 8'h00);
        // cause flags set by sources and cleared by zero
        raise(3'h2);
        op(1'h0, WDG_ADR_CAUSE, 8'h00, r);
        check(r, 8'h05);
        raise(3'h1);
        op(1'h0, WDG_ADR_CAUSE, 8'h00, r);
        check(r, 8'h07);
        op(1'h1, WDG_ADR_CAUSE, 8'h00, r);
        op(1'h0, WDG_ADR_CAUSE, 8'h00, r);
        check(r, 8'h00);
        raise(3'h3);
        raise(3'h4);
        op(1'h0, WDG_ADR_CAUSE, 8'h00, r);
        check(r, 8'h01);
        // enable, then a clear outside the window is ignored
        cur = 4'h0;
        op(1'h1, WDG_ADR_CTRL, ctrl_val(cur, 1'h1), r);
        op(1'h1, WDG_ADR_CTRL, 8'h00, r);
        op(1'h0, WDG_ADR_CTRL, 8'h00, r);
        check(r, ctrl_val(cur, 1'h1));
        // timed sequence with random legal and reserved periods
        for (int i = 0; i < 8; i++) begin
            per = (i < 6) ? 4'($urandom % 10) : 4'(10 + $urandom % 6);
            op(1'h1, WDG_ADR_CMD, 8'h01, r);
            op(1'h1, WDG_ADR_CTRL, ctrl_val(cur, 1'h1) | 8'h10, r);
            op(1'h1, WDG_ADR_CTRL, ctrl_val(per, 1'h1), r);
            if (per <= WDG_PER_MAX) begin
                cur = per;
            end
            op(1'h0, WDG_ADR_CTRL, 8'h00, r);
            check(r, ctrl_val(cur, 1'h1));
        end
        // window closes by itself: a late clear is refused
        op(1'h1, WDG_ADR_CTRL, ctrl_val(cur, 1'h1) | 8'h10, r);
        op(1'h0, WDG_ADR_CTRL, 8'h00, r);
        check(r, ctrl_val(cur, 1'h1) | 8'h10);
        op(1'h1, WDG_ADR_CTRL, 8'h00, r);
        op(1'h0, WDG_ADR_CTRL, 8'h00, r);
        check(r, ctrl_val(cur, 1'h1));
        // clear the cause flags, then turn off through the window
        op(1'h1, WDG_ADR_CAUSE, 8'h00, r);
        op(1'h0, WDG_ADR_CAUSE, 8'h00, r);
        check(r, 8'h00);
        op(1'h1, WDG_ADR_CTRL, ctrl_val(cur, 1'h1) | 8'h10, r);
        op(1'h1, WDG_ADR_CTRL, 8'h00, r);
        op(1'h0, WDG_ADR_CTRL, 8'h00, r);
        check(r, 8'h00);
        // fuse forces reset enable and blocks irq enable
        fuse <= 1'h1;
        @(posedge mclk);
        op(1'h1, WDG_ADR_CTRL, 8'h40, r);
        op(1'h0, WDG_ADR_CTRL, 8'h00, r);
        check(r, 8'h08);
        fuse <= 1'h0;
        @(posedge mclk);
        check({7'h00, seen[1]}, 8'h00);
        check({7'h00, seen[0]}, 8'h00);
        conclude();
    end
endmodule
